/* hdl/fpc_top.sv */
// frame pulse, output clock and delayed pulse generator with avalon registers
//
// Function
// [R1] pulse 1 low or high by polarity bit
// [R2] pulse 1 straddles or starts at boundary
// [R3] clock 0 falling or rising edge at boundary
// [R4] pulse 0 low or high by polarity bit
// [R5] pulse 0 straddles or starts at boundary
// [R6] software keeps divided clocks under input clock
// [R7] three delayed pulses, own control registers
// [R8] eight bit channel offset in bits 9-2
// [R9] rate field picks width, offset range, controls
// [R10] software writes zero to bits 15-10
// [R11] read only lock word, one bit per stream
// [R12] clock 2 falling or rising edge at boundary
`timescale 1ns/1ps
`default_nettype none
module fpc_top
  import fpc_pkg::*;
#(
  parameter int HALF_DIV = fpc_pkg::HALF_TICK_CYC
)(
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  input  wire fpc_pkg::fpc_avm_req_t avm_req,
  output logic [31:0]                avm_readdata,
  output logic                       avm_waitrequest,
  input  wire logic                  frame_sync_in,
  input  wire logic [15:0]           ber_lock_in,
  output logic                       frame_pulse_out_0,
  output logic                       frame_pulse_out_1,
  output logic                       ref_clock_out_0,
  output logic                       ref_clock_out_2,
  output logic [2:0]                 delayed_pulse_out,
  output logic                       irq
);
  // registers
  logic [8:0]   select_r;
  fpc_dly_t     dly_r [3];
  logic [2:0]   irq_st_r;
  logic [2:0]   irq_msk_r;
  logic         wait_r;
  logic [31:0]  rdata_r;
  // synchronisers
  logic         fsync_s1_r;
  logic         fsync_s2_r;
  logic         fsync_d_r;
  logic [15:0]  lock_s1_r;
  logic [15:0]  lock_s2_r;
  logic [15:0]  lock_d_r;
  // timebase
  logic [7:0]   div_r;
  logic [11:0]  half_r;
  logic         ck0_r;
  logic         ck2_r;
  logic         fp0_r;
  logic         fp1_r;
  logic [2:0]   dly_out_r;

  // bus decode
  wire          req_any   = avm_req.read | avm_req.write;
  wire          accept    = req_any & ~wait_r;
  wire          wr_ok     = accept & avm_req.write;
  wire          hit_sel   = avm_req.address == OFS_SELECT;
  wire          hit_d0    = avm_req.address == OFS_DLY0;
  wire          hit_d1    = avm_req.address == OFS_DLY1;
  wire          hit_d2    = avm_req.address == OFS_DLY2;
  wire          hit_lock  = avm_req.address == OFS_LOCK;
  wire          hit_st    = avm_req.address == OFS_IRQ_ST;
  wire          hit_msk   = avm_req.address == OFS_IRQ_MSK;
  wire [15:0]   wd        = avm_req.writedata[15:0];
  wire [1:0]    be        = avm_req.byteenable[1:0];
  wire [15:0]   be_mask   = {{8{be[1]}}, {8{be[0]}}};
  wire [2:0]    hit_dly   = {hit_d2, hit_d1, hit_d0};

  // read mux, unmapped reads return zero
  wire [15:0]   rd_dly0   = {6'h00, dly_r[0]};
  wire [15:0]   rd_dly1   = {6'h00, dly_r[1]};
  wire [15:0]   rd_dly2   = {6'h00, dly_r[2]};
  wire [15:0]   rd_mux    = hit_sel  ? {7'h00, select_r} :
                            hit_d0   ? rd_dly0 :
                            hit_d1   ? rd_dly1 :
                            hit_d2   ? rd_dly2 :
                            hit_lock ? lock_s2_r :             // [R11]
                            hit_st   ? {13'h0, irq_st_r} :
                            hit_msk  ? {13'h0, irq_msk_r} : 16'h0000;

  // masked write values
  wire [8:0]    sel_wr    = (select_r & ~be_mask[8:0]) | (wd[8:0] & be_mask[8:0]);
  wire [2:0]    msk_wr    = (irq_msk_r & ~be_mask[2:0]) | (wd[2:0] & be_mask[2:0]);
  wire [2:0]    st_clr    = (wr_ok & hit_st) ? (wd[2:0] & be_mask[2:0]) : 3'h0;

  // timebase events
  wire          fsync_rise = fsync_s2_r & ~fsync_d_r;
  wire          half_tick  = div_r == 8'(HALF_DIV - 1);
  wire          resync     = fsync_rise & (half_r != 12'h000);
  wire          lock_chg   = lock_s2_r != lock_d_r;
  wire          frame_evt  = half_tick & (half_r == 12'hfff);
  wire [2:0]    irq_set    = {resync, lock_chg, frame_evt};
  wire [11:0]   half_nxt   = fsync_rise ? 12'h000 : half_tick ? half_r + 12'h001 : half_r;

  // control select decoded
  wire          p0_pos    = select_r[BIT_P0_POS];
  wire          p0_pol    = select_r[BIT_P0_POL];
  wire          ck0_pol   = select_r[BIT_CK0_POL];
  wire          p1_pos    = select_r[BIT_P1_POS];
  wire          p1_pol    = select_r[BIT_P1_POL];
  wire          p2_pos    = select_r[BIT_P2_POS];
  wire          ck2_pol   = select_r[BIT_CK2_POL];
  wire          p2_pol    = select_r[BIT_P2_POL];

  // output clocks: 4.096 and 8.192 MHz, edge at count zero chosen by polarity
  wire          ck0_nxt   = ck0_pol ? ~half_nxt[2] : half_nxt[2];   // [R3]
  wire          ck2_nxt   = ck2_pol ? ~half_nxt[1] : half_nxt[1];   // [R12]

  // frame pulses 0 and 1: straddle starts half a width early
  wire [11:0]   fp0_start = p0_pos ? 12'h000 : 12'h000 - 12'({FP0_WIDTH[3:1]}); // [R5]
  wire [11:0]   fp1_start = p1_pos ? 12'h000 : 12'h000 - 12'({FP1_WIDTH[3:1]}); // [R2]
  wire [11:0]   fp0_diff  = half_nxt - fp0_start;
  wire [11:0]   fp1_diff  = half_nxt - fp1_start;
  wire          fp0_act   = fp0_diff < 12'(FP0_WIDTH);
  wire          fp1_act   = fp1_diff < 12'(FP1_WIDTH);
  wire          fp0_nxt   = p0_pol ? fp0_act : ~fp0_act;           // [R4]
  wire          fp1_nxt   = p1_pol ? fp1_act : ~fp1_act;           // [R1]

  // delayed pulses, one slice each
  logic [2:0]   dly_nxt;
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_dly
      fpc_rate_t  rate;
      logic [7:0] ofs_m;
      logic [11:0] point;
      logic [3:0] width;
      logic       pos;
      logic       pol;
      logic [11:0] start;
      logic [11:0] diff;
      logic       act;
      assign rate  = dly_r[g].rate_sel;                            // [R9]
      // offset limited to the permitted range of the rate
      assign ofs_m = (rate == RATE_2M) ? {3'h0, dly_r[g].channel_offset[4:0]} :
                     (rate == RATE_4M) ? {2'h0, dly_r[g].channel_offset[5:0]} :
                     (rate == RATE_8M) ? {1'h0, dly_r[g].channel_offset[6:0]} :
                                         dly_r[g].channel_offset;  // [R8] [R9]
      // channel length in half ticks: 128, 64, 32, 16
      assign point = (rate == RATE_2M) ? {ofs_m[4:0], 7'h00} :
                     (rate == RATE_4M) ? {ofs_m[5:0], 6'h00} :
                     (rate == RATE_8M) ? {ofs_m[6:0], 5'h00} :
                                         {ofs_m, 4'h0};            // [R8]
      // one 4.096, 8.192, 16.384, 16.384 MHz period wide
      assign width = (rate == RATE_2M) ? 4'h8 :
                     (rate == RATE_4M) ? 4'h4 : 4'h2;              // [R9]
      assign pos   = (rate == RATE_2M) ? p0_pos :
                     (rate == RATE_4M) ? p1_pos : p2_pos;          // [R9]
      assign pol   = (rate == RATE_2M) ? p0_pol :
                     (rate == RATE_4M) ? p1_pol : p2_pol;          // [R9]
      assign start = pos ? point : point - 12'({width[3:1]});
      assign diff  = half_nxt - start;
      assign act   = diff < 12'(width);
      assign dly_nxt[g] = pol ? act : ~act;                        // [R7]
    end
  endgenerate

  // bus answer: one wait cycle, then accept
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      wait_r  <= ~(req_any & wait_r);
      rdata_r <= (req_any & wait_r) ? {16'h0000, rd_mux} : rdata_r;
    end
  end

  // control registers
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      select_r  <= RST_SELECT;
      irq_msk_r <= RST_IRQ;
    end
    else
    begin
      if (wr_ok && hit_sel)
        select_r <= sel_wr;
      if (wr_ok && hit_msk)
        irq_msk_r <= msk_wr;
    end
  end

  // offset registers, bits above 9 not stored
  generate
    for (g = 0; g < 3; g++)
    begin : g_dreg
      always_ff @(posedge ref_clk)
      begin
        if (!rstn)
          dly_r[g] <= RST_DLY;
        else if (wr_ok && hit_dly[g])
          dly_r[g] <= (dly_r[g] & ~be_mask[9:0]) | (wd[9:0] & be_mask[9:0]); // [R10]
      end
    end
  endgenerate

  // sticky status, set beats clear
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      irq_st_r <= RST_IRQ;
    else
      irq_st_r <= (irq_st_r & ~st_clr) | irq_set;
  end

  // input synchronisers
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      fsync_s1_r <= 1'b0;
      fsync_s2_r <= 1'b0;
      fsync_d_r  <= 1'b0;
      lock_s1_r  <= 16'h0000;
      lock_s2_r  <= 16'h0000;
      lock_d_r   <= 16'h0000;
    end
    else
    begin
      fsync_s1_r <= frame_sync_in;
      fsync_s2_r <= fsync_s1_r;
      fsync_d_r  <= fsync_s2_r;
      lock_s1_r  <= ber_lock_in;
      lock_s2_r  <= lock_s1_r;
      lock_d_r   <= lock_s2_r;
    end
  end

  // half tick divider and frame counter
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      div_r  <= 8'h00;
      half_r <= 12'h000;
    end
    else
    begin
      div_r  <= (fsync_rise | half_tick) ? 8'h00 : div_r + 8'h01;
      half_r <= half_nxt;
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      ck0_r     <= 1'b0;
      ck2_r     <= 1'b0;
      fp0_r     <= 1'b1;
      fp1_r     <= 1'b1;
      dly_out_r <= 3'h7;
      irq       <= 1'b0;
    end
    else
    begin
      ck0_r     <= ck0_nxt;
      ck2_r     <= ck2_nxt;
      fp0_r     <= fp0_nxt;
      fp1_r     <= fp1_nxt;
      dly_out_r <= dly_nxt;
      irq       <= |(((irq_st_r & ~st_clr) | irq_set) & irq_msk_r);
    end
  end

  assign avm_readdata      = rdata_r;
  assign avm_waitrequest   = wait_r;
  assign ref_clock_out_0   = ck0_r;
  assign ref_clock_out_2   = ck2_r;
  assign frame_pulse_out_0 = fp0_r;
  assign frame_pulse_out_1 = fp1_r;
  assign delayed_pulse_out = dly_out_r;
endmodule
`default_nettype wire

/* include/fpc_pkg.sv */
// constants and types for the frame pulse and clock output block
package fpc_pkg;
  // register byte addresses
  localparam logic [7:0] OFS_SELECT  = 8'h00;
  localparam logic [7:0] OFS_DLY0    = 8'h04;
  localparam logic [7:0] OFS_DLY1    = 8'h08;
  localparam logic [7:0] OFS_DLY2    = 8'h0c;
  localparam logic [7:0] OFS_LOCK    = 8'h10;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h14;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h18;
  // select register field positions
  localparam int BIT_P0_POS  = 0;
  localparam int BIT_P0_POL  = 1;
  localparam int BIT_CK0_POL = 2;
  localparam int BIT_P1_POS  = 3;
  localparam int BIT_P1_POL  = 4;
  localparam int BIT_P2_POS  = 6;
  localparam int BIT_CK2_POL = 7;
  localparam int BIT_P2_POL  = 8;
  // offset register fields
  localparam int DLY_RATE_LSB = 0;
  localparam int DLY_OFS_LSB  = 2;
  localparam int DLY_OFS_MSB  = 9;
  // reset values
  localparam logic [8:0]  RST_SELECT = 9'h000;
  localparam logic [9:0]  RST_DLY    = 10'h000;
  localparam logic [2:0]  RST_IRQ    = 3'h0;
  // interrupt status bits
  localparam int IRQ_FRAME  = 0;
  localparam int IRQ_LOCK   = 1;
  localparam int IRQ_RESYNC = 2;
  // timing in half periods of the 16.384 MHz grid
  localparam int         HALF_TICK_NS  = 30;
  localparam int         REF_CLK_NS    = 5;
  localparam int         HALF_TICK_CYC = (HALF_TICK_NS + REF_CLK_NS - 1) / REF_CLK_NS;
  localparam logic [3:0] FP0_WIDTH     = 4'h8;  // 244 ns class pulse
  localparam logic [3:0] FP1_WIDTH     = 4'h4;  // 122 ns class pulse
  // delayed pulse data rates
  typedef enum logic [1:0] {RATE_2M = 2'h0, RATE_4M = 2'h1, RATE_8M = 2'h2, RATE_16M = 2'h3}
    fpc_rate_t;
  typedef struct packed {
    logic [7:0] channel_offset;
    fpc_rate_t  rate_sel;
  } fpc_dly_t;
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } fpc_avm_req_t;
endpackage

/* verification/fpc_chk.sv */
// bus handshake, readback and reference clock assertions
`timescale 1ns/1ps
`default_nettype none
module fpc_chk
  import fpc_pkg::*;
#(
  parameter int HALF_DIV = 6
)(
  input wire logic                  ref_clk,
  input wire logic                  rstn,
  input wire fpc_pkg::fpc_avm_req_t avm_req,
  input wire logic [31:0]           avm_readdata,
  input wire logic                  avm_waitrequest,
  input wire logic                  frame_sync_in,
  input wire logic [15:0]           ber_lock_in,
  input wire logic                  ref_clock_out_0,
  input wire logic                  ref_clock_out_2,
  input wire logic                  irq
);
  logic [15:0] run0_r;
  logic [15:0] run2_r;
  logic [15:0] quiet_r;
  // cycles since each clock edge, and since the last write or frame sync change
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      run0_r  <= 16'h0;
      run2_r  <= 16'h0;
      quiet_r <= 16'h0;
    end
    else
    begin
      run0_r  <= $changed(ref_clock_out_0) ? 16'h1 : run0_r + 16'h1;
      run2_r  <= $changed(ref_clock_out_2) ? 16'h1 : run2_r + 16'h1;
      quiet_r <= (avm_req.write || $changed(frame_sync_in)) ? 16'h0 : quiet_r + {15'h0, !quiet_r[8]};
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_ack; (avm_req.read || avm_req.write) && avm_waitrequest |=> !avm_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("request not answered");
  property p_one; !avm_waitrequest |=> avm_waitrequest; endproperty
  a_one: assert property (p_one) else $error("wait low too long");
  property p_hi; !avm_waitrequest |-> avm_readdata[31:16] == 16'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_lock; avm_req.read && !avm_waitrequest && avm_req.address == OFS_LOCK
    && ber_lock_in == $past(ber_lock_in, 5) |-> avm_readdata == {16'h0, ber_lock_in}; endproperty
  a_lock: assert property (p_lock) else $error("lock word wrong");
  property p_unmap; avm_req.read && !avm_waitrequest && avm_req.address > OFS_IRQ_MSK
    |-> avm_readdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_rst; $rose(rstn) |-> avm_waitrequest && !irq; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_ck0; $changed(ref_clock_out_0) && quiet_r > 16'h40 |-> run0_r == 16'(4 * HALF_DIV);
  endproperty
  a_ck0: assert property (p_ck0) else $error("clock 0 half period");
  property p_ck2; $changed(ref_clock_out_2) && quiet_r > 16'h40 |-> run2_r == 16'(2 * HALF_DIV);
  endproperty
  a_ck2: assert property (p_ck2) else $error("clock 2 half period");
endmodule
bind fpc_top fpc_chk #(.HALF_DIV(HALF_DIV)) u_chk (
  .ref_clk(ref_clk), .rstn(rstn), .avm_req(avm_req), .avm_readdata(avm_readdata),
  .avm_waitrequest(avm_waitrequest), .frame_sync_in(frame_sync_in), .ber_lock_in(ber_lock_in),
  .ref_clock_out_0(ref_clock_out_0), .ref_clock_out_2(ref_clock_out_2), .irq(irq));
`default_nettype wire

/* verification/fpc_far.sv */
// downstream model: stamps active edges and times active spells
`timescale 1ns/1ps
`default_nettype none
module fpc_far (
  input  wire logic       ref_clk,
  input  wire logic [6:0] line,
  input  wire logic [6:0] act,
  output int              t_start [7],
  output int              width   [7]
);
  int         now  = 0;
  logic [6:0] prev = 7'h0;
  // a line going active is stamped, leaving it gives the width
  always @(posedge ref_clk)
  begin
    now = now + 1;
    for (int i = 0; i < 7; i++)
    begin
      if (line[i] === act[i] && prev[i] !== act[i])
        t_start[i] = now;
      if (line[i] !== act[i] && prev[i] === act[i])
        width[i] = now - t_start[i];
    end
    prev = line;
  end
endmodule
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench: registers, interrupt, pulse and clock timing
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fpc_pkg::*;
  localparam int HD = 2;  // half tick in cycles, output clocks stay under ref_clk
  localparam int F  = 4096 * HD;
  logic         ref_clk = 1'b0;
  logic         rstn    = 1'b0;
  logic         fsync   = 1'b0;
  fpc_avm_req_t req     = '0;
  logic [15:0]  ber     = 16'h0;
  logic [15:0]  lf      = 16'h26e3;
  logic [31:0]  rdata;
  logic [31:0]  q;
  logic         wt;
  logic         irq;
  wire logic [6:0] line;
  logic [6:0]   act     = 7'h60;
  logic [8:0]   sel     = 9'h0;
  int           t_start [7];
  int           width   [7];
  int           mdl     [9];
  int           rt      [5] = '{0, 1, 0, 0, 0};
  int           of      [5] = '{0, 0, 0, 0, 0};
  int           unit    [4] = '{128, 64, 32, 16};
  int           wd      [4] = '{8, 4, 2, 2};
  int           posb    [4] = '{0, 3, 6, 6};
  int           polb    [4] = '{1, 4, 8, 8};
  int           adr     [7] = '{0, 4, 8, 12, 16, 24, 32};
  int           miscompares = 0;
  int           n_compared  = 0;
  fpc_top #(.HALF_DIV(HD)) DUT (.ref_clk(ref_clk), .rstn(rstn), .avm_req(req),
    .avm_readdata(rdata), .avm_waitrequest(wt), .frame_sync_in(fsync), .ber_lock_in(ber),
    .frame_pulse_out_0(line[0]), .frame_pulse_out_1(line[1]), .ref_clock_out_0(line[5]),
    .ref_clock_out_2(line[6]), .delayed_pulse_out(line[4:2]), .irq(irq));
  fpc_far far (.ref_clk(ref_clk), .line(line), .act(act), .t_start(t_start), .width(width));
  // free running clock
  always #2.5 ref_clk = ~ref_clk;
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic int md(input int v, input int m);
    return ((v % m) + m) % m;
  endfunction
  // pulse start in half ticks from the boundary, offset cut to the rate's range
  function automatic int st(input int i);
    return of[i] % (32 << rt[i]) * unit[rt[i]] - (sel[posb[rt[i]]] ? 0 : wd[rt[i]] / 2);
  endfunction
  task automatic report_and_stop(input bit hung);
    if (hung)
      miscompares++;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{a, !w, w, d, 4'h3};
    @(posedge ref_clk);
    while (wt !== 1'b0)
    begin
      n = n + 1;
      if (n > 50)
        report_and_stop(1'b1);
      @(posedge ref_clk);
    end
    q = rdata;
    req.read  <= 1'b0;
    req.write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wrm(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
    mdl[a / 4] = d & (a == 0 ? 'h1ff : a < 16 ? 'h3ff : a == 24 ? 7 : 0);
  endtask
  task automatic rdc(input logic [7:0] a);
    bus(a, 1'b0, 32'h0);
    chk(q, a == 16 ? {16'h0, ber} : mdl[a / 4]);
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rstn  <= 1'b1;
    ber   <= lf;
    fsync <= 1'b1;
    // reset values, then written values read back with bits 15-10 zero
    for (int p = 0; p < 2; p++)
      foreach (adr[i])
      begin
        lf = nx(lf);
        if (p == 1)
          wrm(adr[i], {22'h0, lf[9:0]});
        rdc(adr[i]);
      end
    $display("registers done");
    // lock change and frame wrap raise, mask and clear the interrupt
    wrm(8'h14, 32'h7);
    wrm(8'h18, 32'h2);
    ber <= ~ber;
    repeat (8) @(posedge ref_clk);
    chk(irq, 1'b1);
    wrm(8'h14, 32'h2);
    chk(irq, 1'b0);
    wrm(8'h18, 32'h1);
    repeat (F) @(posedge ref_clk);
    chk(irq, 1'b1);
    wrm(8'h18, 32'h0);
    // irq register follows the mask register one edge later
    @(posedge ref_clk);
    chk(irq, 1'b0);
    // frame sync edge away from the boundary raises the resync bit
    wrm(8'h18, 32'h4);
    @(posedge ref_clk);
    chk(irq, 1'b0);
    fsync <= 1'b0;
    repeat (4) @(posedge ref_clk);
    fsync <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(irq, 1'b1);
    $display("interrupt done");
    // every rate on each delayed pulse, random offsets and select bits
    for (int it = 0; it < 4; it++)
    begin
      lf  = nx(lf);
      sel = lf[8:0];
      wrm(8'h00, {23'h0, sel});
      for (int n = 2; n < 5; n++)
      begin
        lf    = nx(lf);
        rt[n] = (it + n) % 4;
        of[n] = lf[15:8];
        wrm(8'(4 * n - 4), {22'h0, lf[15:8], 2'(rt[n])});
      end
      foreach (rt[i])
        act[i] <= sel[polb[rt[i]]];
      repeat (2 * F + 100) @(posedge ref_clk);
      foreach (rt[i])
      begin
        chk(width[i], wd[rt[i]] * HD);
        chk(md(t_start[i] - t_start[0], F), md((st(i) - st(0)) * HD, F));
      end
      chk(md(t_start[5] - t_start[0] + st(0) * HD, 8 * HD), sel[2] ? 0 : 4 * HD);
      chk(md(t_start[6] - t_start[0] + st(0) * HD, 4 * HD), sel[7] ? 0 : 2 * HD);
      $display("timing pass %0d done", it);
    end
    report_and_stop(1'b0);
  end
endmodule
`default_nettype wire
